// ---- rtl/dtdq_pkg.sv ----
package dtdq_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  localparam int HALF_MS_NS      = 500000;
  // qualification timers step in half milliseconds of wall time
  localparam int HALF_MS_CYCLES  = HALF_MS_NS / CLK_PERIOD_NS;
  localparam int DETECT_RATE_HZ  = 8000;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [8:0] ADDR_DET_CTRL   = 9'h1e0;
  localparam logic [8:0] ADDR_Q_CTRL     = 9'h1e1;
  localparam logic [8:0] ADDR_Q_READ     = 9'h1e2;
  localparam logic [8:0] ADDR_Q_STATUS   = 9'h1e3;
  localparam logic [8:0] ADDR_THRES_HI   = 9'h1e4;
  localparam logic [8:0] ADDR_THRES_LO   = 9'h1e5;
  localparam logic [8:0] ADDR_PRESENT_T  = 9'h1e6;
  localparam logic [8:0] ADDR_ABSENT_T   = 9'h1e7;
  localparam logic [8:0] ADDR_ACCEPT_T   = 9'h1e8;
  localparam logic [8:0] ADDR_RX_DIGIT   = 9'h1ea;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_DET_CTRL   = 8'h00;
  localparam logic [7:0]  RST_Q_CTRL     = 8'h40;
  localparam logic [15:0] RST_THRES      = 16'h0100;
  localparam logic [7:0]  RST_TIMER      = 8'h00;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int EN_BIT      = 7;
  localparam int DEV_LSB     = 4;
  localparam int TC_LSB      = 0;
  localparam int LEVEL_LSB   = 4;
  localparam int CLR_BIT     = 0;
  localparam int FULL_BIT    = 1;
  localparam int EMPTY_BIT   = 0;
  localparam int CNT_LSB     = 4;
  localparam int RDY_BIT     = 7;
  localparam int STATE_BIT   = 6;

  // ----------------------------------------------------------------------
  // tone plan and decoding
  // ----------------------------------------------------------------------
  localparam int QUEUE_DEPTH     = 8;
  localparam int FREQ_FRAC_BITS  = 3;
  localparam int PERMILLE_SCALE  = 1000;
  localparam int THRESH_SHIFT    = 8;
  localparam int ROW_HZ [4]      = '{697, 770, 852, 941};
  localparam int COL_HZ [4]      = '{1209, 1336, 1477, 1633};
  localparam int DEV_PERMILLE [4] = '{20, 25, 30, 35};
  // indexed by {row, column}
  localparam logic [3:0] DIGIT_TABLE [16] = '{
    4'h1, 4'h2, 4'h3, 4'hd,
    4'h4, 4'h5, 4'h6, 4'he,
    4'h7, 4'h8, 4'h9, 4'hf,
    4'hb, 4'ha, 4'hc, 4'h0};

  function automatic logic [3:0] dtdq_digit(input logic [1:0] row,
                                            input logic [1:0] col);
    dtdq_digit = DIGIT_TABLE[{row, col}];
  endfunction : dtdq_digit

endpackage : dtdq_pkg

// ---- rtl/dtdq_tone_match.sv ----
`timescale 1ns/1ps
module dtdq_tone_match #(
  parameter bit IS_COL = 1'b0
) (
  // estimate in 13.3 format
  input  wire logic [15:0] freq,
  input  wire logic [1:0]  tol_sel,
  // match result
  output logic             hit,
  output logic [1:0]       idx
);
  import dtdq_pkg::*;

  // ----------------------------------------------------------------------
  // tolerance window, done as cross products to avoid a divider
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [31:0] nom;
    logic [31:0] diff;
    nom  = 32'h0;
    diff = 32'h0;
    hit  = 1'b0;
    idx  = 2'h0;
    for (int i = 0; i < 4; i++)
    begin
      nom  = 32'(IS_COL ? COL_HZ[i] : ROW_HZ[i]) << FREQ_FRAC_BITS;
      diff = ({16'h0, freq} > nom) ? {16'h0, freq} - nom
                                   : nom - {16'h0, freq};
      if (!hit && (diff * 32'(PERMILLE_SCALE) <=
                   nom * 32'(DEV_PERMILLE[tol_sel])))
      begin
        hit = 1'b1;
        idx = 2'(i);
      end
    end
  end

endmodule : dtdq_tone_match

// ---- rtl/dtdq_top.sv ----
`timescale 1ns/1ps
// Function
// - row and column nominal tone frequencies
// - scan samples only while enabled
// - energy, tolerance, present time set detect
// - both detect flags give tone-present state
// - accept time elapsed: ready, decode, push
// - absent time outside tolerance clears flag
// - interrupt to host when queue depth exceeds level
// - detector runs only at 8 kHz
// - digit code table for sixteen keys
// - tolerance codes give 2.0 to 3.5 percent
// - time constant sets energy averaging speed
// - queue interrupt at level plus one
// - queue clear empties queue, depth zero
// - queue read returns oldest, then pops
// - queue read upper bits: depth before pop
// - status: count, full bit1, empty bit0
// - eight entries, digit dropped when full
// - below energy threshold no digit reported
// - present and absent times in 0.5 ms
// - accept time is value plus one steps
// - received digit register ready, state, code
module dtdq_top #(
  parameter int HALF_MS_CYC = dtdq_pkg::HALF_MS_CYCLES,
  parameter int Q_DEPTH     = dtdq_pkg::QUEUE_DEPTH
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // register access port
  input  wire logic [8:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [7:0]  REG_WDATA,
  output logic [7:0]       REG_RDATA,
  // channel path, same clock
  input  wire logic        SMP_VALID,
  input  wire logic [15:0] SMP_DATA,
  input  wire logic        RATE_8K,
  input  wire logic [15:0] ROW_FREQ,
  input  wire logic [15:0] COL_FREQ,
  // host interrupt
  output logic             DIGIT_IRQ
);
  import dtdq_pkg::*;

  localparam int PW = $clog2(Q_DEPTH);
  localparam int TW = $clog2(HALF_MS_CYC);

  // refuse sizes the pointer and status fields cannot carry
  if (Q_DEPTH != 8 || HALF_MS_CYC < 2)
  begin : g_bad_cfg
    $error("dtdq_top: unsupported queue depth or tick length");
  end

  typedef enum logic [1:0] {ACC_WAIT, ACC_COUNT, ACC_DONE} dtdq_acc_type;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0]    ctrl_r, ctrl_nxt;
  logic [2:0]    level_r, level_nxt;
  logic [15:0]   thres_r, thres_nxt;
  logic [7:0]    pdt_r, pdt_nxt, adt_r, adt_nxt, acct_r, acct_nxt;
  logic [7:0]    rdata_r, rdata_nxt;
  logic          irq_r, irq_nxt;
  logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
  logic          tick;
  logic [31:0]   avg_r, avg_nxt;
  logic          run, energy_ok;
  logic [1:0]    flag, tone_hit;
  logic [1:0]    held_idx [2];
  dtdq_acc_type  acc_r, acc_nxt;
  logic [7:0]    acc_cnt_r, acc_cnt_nxt;
  logic [3:0]    last_digit_r, last_digit_nxt;
  logic [3:0]    q_mem_r [Q_DEPTH];
  logic [3:0]    q_mem_nxt [Q_DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0]   cnt_r, cnt_nxt;
  logic          push, pop, q_clear, q_full, q_empty, tone_state, rd_q;

  assign run       = ctrl_r[EN_BIT] & RATE_8K;
  assign tick      = (tick_cnt_r == TW'(HALF_MS_CYC - 1));
  assign q_full    = (cnt_r == (PW+1)'(Q_DEPTH));
  assign q_empty   = (cnt_r == '0);
  assign tone_state = &flag;
  assign rd_q      = REG_RD && REG_ADDR == ADDR_Q_READ;
  assign q_clear   = REG_WR && REG_ADDR == ADDR_Q_CTRL && REG_WDATA[CLR_BIT];
  assign pop       = rd_q && !q_empty;
  assign push      = (acc_nxt == ACC_DONE) && (acc_r != ACC_DONE)
                     && !q_full;

  // ----------------------------------------------------------------------
  // register writes and half-millisecond tick
  // ----------------------------------------------------------------------
  always_comb
  begin
    ctrl_nxt     = ctrl_r;
    level_nxt    = level_r;
    thres_nxt    = thres_r;
    pdt_nxt      = pdt_r;
    adt_nxt      = adt_r;
    acct_nxt     = acct_r;
    tick_cnt_nxt = (tick || !run) ? '0 : tick_cnt_r + 1'b1;
    if (REG_WR)
    begin
      unique case (REG_ADDR)
        ADDR_DET_CTRL:  ctrl_nxt  = REG_WDATA;
        ADDR_Q_CTRL:    level_nxt = REG_WDATA[LEVEL_LSB +: 3];
        ADDR_THRES_HI:  thres_nxt = {REG_WDATA, thres_r[7:0]};
        ADDR_THRES_LO:  thres_nxt = {thres_r[15:8], REG_WDATA};
        ADDR_PRESENT_T: pdt_nxt   = REG_WDATA;
        ADDR_ABSENT_T:  adt_nxt   = REG_WDATA;
        ADDR_ACCEPT_T:  acct_nxt  = REG_WDATA;
        default:        ;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ctrl_r     <= RST_DET_CTRL;
      level_r    <= RST_Q_CTRL[LEVEL_LSB +: 3];
      thres_r    <= RST_THRES;
      pdt_r      <= RST_TIMER;
      adt_r      <= RST_TIMER;
      acct_r     <= RST_TIMER;
      tick_cnt_r <= '0;
    end
    else
    begin
      ctrl_r     <= ctrl_nxt;
      level_r    <= level_nxt;
      thres_r    <= thres_nxt;
      pdt_r      <= pdt_nxt;
      adt_r      <= adt_nxt;
      acct_r     <= acct_nxt;
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // energy estimate: leaky average of the squared sample
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic signed [31:0] sq;
    logic signed [32:0] delta;
    sq      = $signed(SMP_DATA) * $signed(SMP_DATA);
    delta   = $signed({1'b0, sq}) - $signed({1'b0, avg_r});
    avg_nxt = avg_r;
    if (!run)
      avg_nxt = '0;
    else if (SMP_VALID) // larger shift: slower but steadier
      avg_nxt = 32'($signed({1'b0, avg_r})
                + (delta >>> ctrl_r[TC_LSB +: 4]));
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      avg_r <= '0;
    else
      avg_r <= avg_nxt;
  end

  // signal below threshold makes the estimator results void
  assign energy_ok = avg_r[31:THRESH_SHIFT] >= {8'h00, thres_r};

  // ----------------------------------------------------------------------
  // row and column detect flags
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < 2; g++)
  begin : g_grp
    logic       m_hit;
    logic [1:0] m_idx;
    logic       flag_r, flag_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic [7:0] tcnt_r, tcnt_nxt;

    dtdq_tone_match #(
      .IS_COL (g == 1)
    ) u_match (
      .freq    (g == 1 ? COL_FREQ : ROW_FREQ),
      .tol_sel (ctrl_r[DEV_LSB +: 2]),
      .hit     (m_hit),
      .idx     (m_idx)
    );

    assign tone_hit[g] = m_hit & energy_ok & run;

    // present timer while clear, absent timer while set
    always_comb
    begin
      flag_nxt = flag_r;
      idx_nxt  = idx_r;
      tcnt_nxt = tcnt_r;
      if (!run)
      begin
        flag_nxt = 1'b0;
        tcnt_nxt = '0;
      end
      else if (!flag_r)
      begin
        if (!tone_hit[g] || m_idx != idx_r)
        begin
          tcnt_nxt = '0;
          idx_nxt  = m_idx;
        end
        else if (tcnt_r >= pdt_r)
        begin
          flag_nxt = 1'b1;
          tcnt_nxt = '0;
        end
        else if (tick)
          tcnt_nxt = tcnt_r + 8'h01;
      end
      else if (tone_hit[g] && m_idx == idx_r)
        tcnt_nxt = '0;
      else if (tcnt_r >= adt_r)
      begin
        flag_nxt = 1'b0;
        tcnt_nxt = '0;
      end
      else if (tick)
        tcnt_nxt = tcnt_r + 8'h01;
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
      if (SYS_RST)
      begin
        flag_r <= 1'b0;
        idx_r  <= 2'h0;
        tcnt_r <= 8'h00;
      end
      else
      begin
        flag_r <= flag_nxt;
        idx_r  <= idx_nxt;
        tcnt_r <= tcnt_nxt;
      end
    end

    assign flag[g]     = flag_r;
    assign held_idx[g] = idx_r;
  end

  // ----------------------------------------------------------------------
  // accept qualification, one push per tone
  // ----------------------------------------------------------------------
  always_comb
  begin
    acc_nxt        = acc_r;
    acc_cnt_nxt    = acc_cnt_r;
    last_digit_nxt = last_digit_r;
    unique case (acc_r)
      ACC_WAIT:
        if (tone_state)
        begin
          acc_nxt     = ACC_COUNT;
          acc_cnt_nxt = '0;
        end
      ACC_COUNT:
        if (!tone_state)
          acc_nxt = ACC_WAIT;
        else if (tick && acc_cnt_r == acct_r)
        begin
          acc_nxt        = ACC_DONE;
          last_digit_nxt = dtdq_digit(held_idx[0], held_idx[1]);
        end
        else if (tick)
          acc_cnt_nxt = acc_cnt_r + 8'h01;
      ACC_DONE:
        if (!tone_state)
          acc_nxt = ACC_WAIT;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      acc_r        <= ACC_WAIT;
      acc_cnt_r    <= 8'h00;
      last_digit_r <= 4'h0;
    end
    else
    begin
      acc_r        <= acc_nxt;
      acc_cnt_r    <= acc_cnt_nxt;
      last_digit_r <= last_digit_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // digit queue and read port
  // ----------------------------------------------------------------------
  always_comb
  begin
    q_mem_nxt = q_mem_r;
    wp_nxt    = wp_r;
    rp_nxt    = rp_r;
    cnt_nxt   = cnt_r;
    if (q_clear)
    begin
      wp_nxt  = '0;
      rp_nxt  = '0;
      cnt_nxt = '0;
    end
    else
    begin
      if (push)
      begin
        q_mem_nxt[wp_r] = last_digit_nxt;
        wp_nxt          = wp_r + 1'b1;
      end
      if (pop)
        rp_nxt = rp_r + 1'b1;
      cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
    // clear wins over a read in the same cycle; it also discards data
    rdata_nxt = rdata_r;
    if (REG_RD)
    begin
      unique case (REG_ADDR)
        ADDR_DET_CTRL:  rdata_nxt = {ctrl_r[7], 1'b0, ctrl_r[5:0]};
        ADDR_Q_CTRL:    rdata_nxt = {1'b0, level_r, 4'h0};
        ADDR_Q_READ:    rdata_nxt = {cnt_r, q_mem_r[rp_r]};
        ADDR_Q_STATUS:  rdata_nxt = {cnt_r, 2'b00, q_full, q_empty};
        ADDR_THRES_HI:  rdata_nxt = thres_r[15:8];
        ADDR_THRES_LO:  rdata_nxt = thres_r[7:0];
        ADDR_PRESENT_T: rdata_nxt = pdt_r;
        ADDR_ABSENT_T:  rdata_nxt = adt_r;
        ADDR_ACCEPT_T:  rdata_nxt = acct_r;
        ADDR_RX_DIGIT:  rdata_nxt = {acc_r == ACC_DONE, tone_state,
                                     2'b00, last_digit_r};
        default:        rdata_nxt = 8'h00;
      endcase
    end
    // level output so a late mask in the host loses nothing
    irq_nxt = (cnt_nxt > {1'b0, level_r});
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      for (int i = 0; i < Q_DEPTH; i++)
        q_mem_r[i] <= 4'h0;
      wp_r    <= '0;
      rp_r    <= '0;
      cnt_r   <= '0;
      rdata_r <= 8'h00;
      irq_r   <= 1'b0;
    end
    else
    begin
      q_mem_r <= q_mem_nxt;
      wp_r    <= wp_nxt;
      rp_r    <= rp_nxt;
      cnt_r   <= cnt_nxt;
      rdata_r <= rdata_nxt;
      irq_r   <= irq_nxt;
    end
  end

  assign REG_RDATA = rdata_r;
  assign DIGIT_IRQ = irq_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_accept_fire;
    acc_r == ACC_COUNT ##1 acc_r == ACC_DONE;
  endsequence

  // ready is left only on the cycle after a flag falls
  sequence s_wait_drop;
    acc_r == ACC_DONE ##1 acc_r == ACC_WAIT;
  endsequence

  a_push_once: assert property (
    push |=> !push)
    else $error("digit pushed twice in a row");
  a_accept_push: assert property (
    $past(acc_r == ACC_COUNT) && acc_r == ACC_DONE && $past(!q_full)
      && !$past(q_clear) |-> cnt_r == $past(cnt_r) + 1'b1 - $past(pop))
    else $error("accepted digit not queued");
  a_full_drop: assert property (
    q_full && !pop && !q_clear |=> cnt_r == (PW+1)'(Q_DEPTH))
    else $error("full queue changed count");
  a_clear_empty: assert property (
    q_clear |=> q_empty && wp_r == rp_r)
    else $error("queue clear left entries");
  a_read_pops: assert property (
    pop && !push |=> cnt_r == $past(cnt_r) - 1'b1 ##1 1'b1)
    else $error("read did not pop");
  a_irq_level: assert property (
    1'b1 |=> irq_r == (cnt_r > {1'b0, $past(level_r, 1)}) || $changed(level_r))
    else $error("queue interrupt level wrong");
  a_state_both: assert property (
    s_accept_fire |-> $past(tone_state, 1) && $past(&flag, 1))
    else $error("ready without both flags");
  a_disable_idle: assert property (
    !run |=> flag == 2'b00 && avg_r == '0)
    else $error("detector active while disabled");
  a_ready_release: assert property (
    s_wait_drop |-> $past(!tone_state, 1))
    else $error("ready dropped while tone still present");

endmodule : dtdq_top

// ---- sim/dtdq_host_model.sv ----
`timescale 1ns/1ps
// host side of the register port: one strobe cycle per access
module dtdq_host_model (
  // clock and answer
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  // request lines
  output logic [8:0]      addr,
  output logic            wr,
  output logic            rd,
  output logic [7:0]      wdata
);
  // quiet bus from time zero
  initial
  begin
    addr  = 9'h000;
    wr    = 1'b0;
    rd    = 1'b0;
    wdata = 8'h00;
  end

  // strobe is taken at the rising edge between the two falling edges
  task automatic put(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge clk);
    wr    = 1'b0;
    wdata = ~d; // stale data must not be mistaken for a write
  endtask : put

  // data is registered on the taking edge, so it is settled here
  task automatic get(input logic [8:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd   = 1'b1;
    @(negedge clk);
    rd   = 1'b0;
    d    = rdata;
  endtask : get
endmodule : dtdq_host_model

// ---- sim/dual_tone_detector_with_queue_test.sv ----
`timescale 1ns/1ps
module dual_tone_detector_with_queue_test;
  import dtdq_pkg::*;
  localparam int RH [4] = '{697, 770, 852, 941};
  localparam int CH [4] = '{1209, 1336, 1477, 1633};
  // each row: {row index, column index, expected digit code}
  localparam logic [7:0] TAB [16] = '{8'h01, 8'h12, 8'h23, 8'h3d,
    8'h44, 8'h55, 8'h66, 8'h7e, 8'h87, 8'h98, 8'ha9, 8'hbf,
    8'hcb, 8'hda, 8'hec, 8'hf0};
  localparam logic [7:0] RSTV [11] = '{8'h00, 8'h40, 8'h00, 8'h01,
    8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic        clk;
  logic        sys_rst;
  logic [8:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        smp_valid = 1'b0;
  logic [15:0] smp_data  = 16'h0000;
  logic        rate_8k   = 1'b1;
  logic [15:0] row_freq  = 16'h0000;
  logic [15:0] col_freq  = 16'h0000;
  logic        digit_irq;
  logic [15:0] amp       = 16'h0400;
  logic [1:0]  sc        = 2'h0;
  logic [7:0]  rv;
  int          fails;
  int          checks_done;
  int          pm;

  dtdq_top #(.HALF_MS_CYC(8), .Q_DEPTH(8)) uut (
    .CLK(clk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .SMP_VALID(smp_valid), .SMP_DATA(smp_data),
    .RATE_8K(rate_8k), .ROW_FREQ(row_freq), .COL_FREQ(col_freq),
    .DIGIT_IRQ(digit_irq));

  dtdq_host_model host (.clk(clk), .rdata(reg_rdata), .addr(reg_addr),
    .wr(reg_wr), .rd(reg_rd), .wdata(reg_wdata));

  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // channel samples every fourth cycle, compressed from 8 kHz for speed
  always @(negedge clk)
  begin
    sc        <= sc + 2'h1;
    smp_valid <= (sc == 2'h0);
    smp_data  <= amp;
  end

  // ------------------------------------------------------------------
  // compare and access helpers
  // ------------------------------------------------------------------
  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk8

  task automatic rchk(input string n, input logic [8:0] a,
                      input logic [7:0] e);
    host.get(a, rv);
    chk8(n, e, rv);
  endtask : rchk

  // estimates in 13.3 format; off shifts the row estimate
  task automatic tone(input logic [1:0] r, input logic [1:0] c,
                      input int off);
    row_freq = 16'(RH[r] * 8 + off);
    col_freq = 16'(CH[c] * 8);
  endtask : tone

  // both tones gone long enough for the absent time to run out
  task automatic idle();
    row_freq = 16'h0000;
    col_freq = 16'h0000;
    repeat (40) @(negedge clk);
  endtask : idle

  // polling is bounded so a stuck queue cannot hang the run
  task automatic wait_cnt(input logic [3:0] n);
    rv = 8'hff;
    for (int i = 0; i < 100 && rv[7:4] !== n; i++)
      host.get(ADDR_Q_STATUS, rv);
    chk8("queue count", {4'h0, n}, {4'h0, rv[7:4]});
  endtask : wait_cnt

  // tone held well past every qualify time, then removed
  task automatic no_digit();
    tone(2'h1, 2'h1, 0);
    repeat (80) @(negedge clk);
    idle();
  endtask : no_digit

  task automatic wrap_up();
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // watchdog sized well above the expected run length
  initial
  begin
    #(60000 * 8);
    fails++;
    wrap_up();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    for (int a = 0; a < 11; a++)
      rchk("reset value", 9'h1e0 + 9'(a), RSTV[a]);
    host.put(9'h1e9, 8'h5a);
    rchk("unmapped", 9'h1e9, 8'h00);
    // low threshold byte stays well under the test signal energy
    host.put(ADDR_THRES_LO, 8'h3c);
    rchk("thres low", ADDR_THRES_LO, 8'h3c);
    host.put(ADDR_PRESENT_T, 8'h01);
    host.put(ADDR_ABSENT_T, 8'h01);
    host.put(ADDR_ACCEPT_T, 8'h00);
    host.put(ADDR_DET_CTRL, 8'h80);
    // every key once; depth 1 on the pop proves a single push
    for (int i = 0; i < 16; i++)
    begin
      tone(TAB[i][7:6], TAB[i][5:4], 0);
      wait_cnt(4'h1);
      rchk("rx digit", ADDR_RX_DIGIT, {4'hc, TAB[i][3:0]});
      repeat (40) @(negedge clk);
      idle();
      rchk("queue head", ADDR_Q_READ, {4'h1, TAB[i][3:0]});
    end
    // tolerance edges 3 permille inside and outside each code
    for (int d = 0; d < 4; d++)
    begin
      pm = 20 + 5 * d;
      host.put(ADDR_DET_CTRL, 8'h80 | 8'(d << 4));
      tone(2'h0, 2'h0, RH[0] * 8 * (pm - 3) / 1000);
      wait_cnt(4'h1);
      idle();
      rchk("inside pop", ADDR_Q_READ, 8'h11);
      tone(2'h0, 2'h0, -(RH[0] * 8 * (pm + 3) / 1000));
      repeat (80) @(negedge clk);
      idle();
      rchk("outside", ADDR_Q_STATUS, 8'h01);
    end
    host.put(ADDR_DET_CTRL, 8'h80);
    // fill past eight; interrupt rises at level plus one
    for (int i = 0; i < 9; i++)
    begin
      tone(TAB[i][7:6], TAB[i][5:4], 0);
      if (i < 8)
        wait_cnt(4'(i + 1));
      else
        repeat (80) @(negedge clk);
      idle();
      chk8("irq", {7'h00, i >= 4}, {7'h00, digit_irq});
    end
    rchk("full status", ADDR_Q_STATUS, 8'h82);
    for (int i = 0; i < 8; i++)
      rchk("pop", ADDR_Q_READ, {4'(8 - i), TAB[i][3:0]});
    rchk("drained", ADDR_Q_STATUS, 8'h01);
    chk8("irq low", 8'h00, {7'h00, digit_irq});
    // level zero, then clear with entries held
    host.put(ADDR_Q_CTRL, 8'h00);
    tone(2'h3, 2'h3, 0);
    wait_cnt(4'h1);
    idle();
    chk8("irq lvl0", 8'h01, {7'h00, digit_irq});
    tone(2'h0, 2'h1, 0);
    wait_cnt(4'h2);
    idle();
    host.put(ADDR_Q_CTRL, 8'h01);
    rchk("cleared", ADDR_Q_STATUS, 8'h01);
    rchk("clear bit", ADDR_Q_CTRL, 8'h00);
    chk8("irq clr", 8'h00, {7'h00, digit_irq});
    // disabled, wrong rate, slow average and high threshold give nothing
    // time constant 15 needs thousands of samples to pass the threshold
    for (int k = 0; k < 4; k++)
    begin
      host.put(ADDR_DET_CTRL, (k == 0) ? 8'h00 : (k == 2) ? 8'h8f : 8'h80);
      rate_8k = (k != 1);
      host.put(ADDR_THRES_HI, (k == 3) ? 8'h20 : 8'h01);
      no_digit();
      rchk("blocked", ADDR_Q_STATUS, 8'h01);
    end
    // reset in mid-run with a digit queued and its tone still held
    host.put(ADDR_THRES_HI, 8'h01);
    tone(2'h1, 2'h2, 0);
    wait_cnt(4'h1);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    rchk("rst status", ADDR_Q_STATUS, 8'h01);
    rchk("rst ctrl", ADDR_DET_CTRL, 8'h00);
    rchk("rst level", ADDR_Q_CTRL, 8'h40);
    rchk("rst digit", ADDR_RX_DIGIT, 8'h00);
    chk8("rst irq", 8'h00, {7'h00, digit_irq});
    wrap_up();
  end
endmodule : dual_tone_detector_with_queue_test
